// File: pabr_pkg.sv
// Package for the PHY identifier, advertisement and partner ability register bank.
// Assumes a single clock domain and an Avalon-MM byte-addressed register slave.
package pabr_pkg;
   // Register indices; byte address is four times the index.
   localparam logic [3:0] IDX_ID_LOW = 4'h3;
   localparam logic [3:0] IDX_ADV = 4'h4;
   localparam logic [3:0] IDX_LP = 4'h5;
   localparam logic [3:0] IDX_PAGE_CTL = 4'h6;
   localparam logic [3:0] IDX_PAGE_STAT = 4'h7;
   // Identifier low word fields.
   localparam int ID_OUI_LSB = 10;
   localparam int ID_MODEL_LSB = 4;
   localparam int ID_REV_LSB = 0;
   // Advertisement bit positions.
   localparam int ADV_NP = 15;
   localparam int ADV_RSV14 = 14;
   localparam int ADV_RF = 13;
   localparam int ADV_XNP = 12;
   localparam int ADV_ASYM = 11;
   localparam int ADV_SYM = 10;
   localparam int ADV_RSV9 = 9;
   localparam int ADV_100FD = 8;
   localparam int ADV_SEL_LSB = 0;
   // Writable advertisement bits; reserved 14 and 9 excluded.
   localparam logic [15:0] ADV_WMASK = 16'hbdff;
   localparam logic [15:0] ADV_RESET = 16'h0101;
   localparam logic [4:0] SEL_IEEE8023 = 5'h01;
   localparam logic [15:0] LP_RESET = 16'h0000;
   // Identifier fields at reset (arbitrary values, not a real maker code).
   localparam logic [5:0] ID_OUI_RESET = 6'h15;
   localparam logic [5:0] ID_MODEL_RESET = 6'h2a;
   localparam logic [3:0] ID_REV_RESET = 4'h1;
   // Page control bit: capture enable.
   localparam int CTL_CAPTURE_EN = 0;
   // Page status bits.
   localparam int STAT_PAGE_RX = 0;
   localparam int STAT_ADV_ACTIVE = 1;
   // Bus response codes.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK = 2'b01
   } pabr_bus_t;
endpackage

// File: pabr_page_capture.sv
// Holds the partner base page word, loaded from each received link code word while capture_en is high.
// Assumes the negotiation engine gives a one-cycle strobe with the word.
`timescale 1ns/1ps
module pabr_page_capture #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Received page
   input wire logic page_strobe,
   input wire logic [W-1:0] page_word,
   input wire logic capture_en,
   // Held word
   output logic [W-1:0] partner_word,
   output logic page_seen
);
   logic [W-1:0] word_r;
   logic seen_r;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         word_r <= pabr_pkg::LP_RESET;
      end else if (page_strobe && capture_en) begin
         word_r <= page_word;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         seen_r <= 1'b0;
      end else if (page_strobe && capture_en) begin
         seen_r <= 1'b1;
      end
   end

   assign partner_word = word_r;
   assign page_seen = seen_r;
endmodule // pabr_page_capture

// File: pabr_bus_slave.sv
// Avalon-MM slave handshake: one wait cycle, then an acknowledge cycle.
// Assumes the master holds its request until waitrequest is seen low.
`timescale 1ns/1ps
module pabr_bus_slave (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Request
   input wire logic read,
   input wire logic write,
   // Handshake
   output logic waitrequest,
   output logic ack
);
   pabr_pkg::pabr_bus_t state_r;
   pabr_pkg::pabr_bus_t state_nxt;

   always_comb begin
      state_nxt = pabr_pkg::BUS_IDLE;
      case (state_r)
         pabr_pkg::BUS_IDLE: begin
            if (read || write) begin
               state_nxt = pabr_pkg::BUS_ACK;
            end
         end
         default: begin
            state_nxt = pabr_pkg::BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_r <= pabr_pkg::BUS_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // The acknowledge cycle is the single edge where the master completes.
   assign ack = (state_r == pabr_pkg::BUS_ACK) && (read || write);
   assign waitrequest = (read || write) && !ack;
endmodule // pabr_bus_slave

// File: pabr_regs.sv
// Register bank for PHY indices 3 to 7: identifier low, advertisement, partner ability, page control, page status.
// Assumes an Avalon-MM master on clk_sys and a negotiation engine giving base pages.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps

module pabr_regs #(
   parameter logic [5:0] OUI_RESET = pabr_pkg::ID_OUI_RESET,
   parameter logic [5:0] MODEL_RESET = pabr_pkg::ID_MODEL_RESET,
   parameter logic [3:0] REV_RESET = pabr_pkg::ID_REV_RESET
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Avalon-MM slave
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic [1:0] response,
   output logic waitrequest,
   // Negotiation engine
   input wire logic page_strobe,
   input wire logic [15:0] page_word,
   output logic [15:0] adv_word,
   output logic next_page_able,
   output logic remote_fault_adv
);
   logic ack;
   logic [3:0] idx;
   logic addr_ok;
   logic [15:0] id_low_r;
   logic [15:0] adv_r;
   logic ctl_r;
   logic [15:0] partner_word;
   logic page_seen;
   logic [15:0] rd_nxt;
   logic [31:0] readdata_r;
   logic [1:0] response_r;
   logic [15:0] wr_lanes;

   pabr_bus_slave u_bus (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .read(read),
      .write(write),
      .waitrequest(waitrequest),
      .ack(ack)
   );

   pabr_page_capture #(.W(16)) u_cap (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .page_strobe(page_strobe),
      .page_word(page_word),
      .capture_en(ctl_r),
      .partner_word(partner_word),
      .page_seen(page_seen)
   );

   // Byte address bits 1:0 must be zero, else decode error; word index sits above them.
   assign idx = address[5:2];
   assign addr_ok = (address[1:0] == 2'h0);
   assign wr_lanes = {{8{byteenable[1]}}, {8{byteenable[0]}}};

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         id_low_r[15:pabr_pkg::ID_OUI_LSB] <= OUI_RESET;
         id_low_r[pabr_pkg::ID_OUI_LSB-1:pabr_pkg::ID_MODEL_LSB] <= MODEL_RESET;
         id_low_r[pabr_pkg::ID_MODEL_LSB-1:pabr_pkg::ID_REV_LSB] <= REV_RESET;
      end else if (ack && write && addr_ok && idx == pabr_pkg::IDX_ID_LOW) begin
         id_low_r <= (writedata[15:0] & wr_lanes) | (id_low_r & ~wr_lanes);
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         adv_r <= pabr_pkg::ADV_RESET;
      end else if (ack && write && addr_ok && idx == pabr_pkg::IDX_ADV) begin
         adv_r <= ((writedata[15:0] & wr_lanes) | (adv_r & ~wr_lanes))
            & pabr_pkg::ADV_WMASK;
      end
   end

   // Capture enable; software may freeze the partner word while inspecting it.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctl_r <= 1'b1;
      end else if (ack && write && addr_ok && idx == pabr_pkg::IDX_PAGE_CTL
         && byteenable[0]) begin
         ctl_r <= writedata[pabr_pkg::CTL_CAPTURE_EN];
      end
   end

   // Read mux; unmapped addresses read zero with a decode error response.
   always_comb begin
      rd_nxt = 16'h0000;
      if (!addr_ok) begin
         rd_nxt = 16'h0000;
      end else if (idx == pabr_pkg::IDX_ID_LOW) begin
         rd_nxt = id_low_r;
      end else if (idx == pabr_pkg::IDX_ADV) begin
         rd_nxt = adv_r;
      end else if (idx == pabr_pkg::IDX_LP) begin
         rd_nxt = partner_word;
      end else if (idx == pabr_pkg::IDX_PAGE_CTL) begin
         rd_nxt = {15'h0000, ctl_r};
      end else if (idx == pabr_pkg::IDX_PAGE_STAT) begin
         rd_nxt = {14'h0000, adv_r[pabr_pkg::ADV_NP], page_seen};
      end
   end

   // Read data is registered in the wait cycle and stands at the ack edge.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         readdata_r <= 32'h00000000;
      end else if ((read || write) && !ack) begin
         readdata_r <= {16'h0000, rd_nxt};
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         response_r <= pabr_pkg::RESP_OKAY;
      end else if ((read || write) && !ack) begin
         if (addr_ok && idx >= pabr_pkg::IDX_ID_LOW && idx <= pabr_pkg::IDX_PAGE_STAT) begin
            response_r <= pabr_pkg::RESP_OKAY;
         end else begin
            response_r <= pabr_pkg::RESP_DECERR;
         end
      end
   end

   assign readdata = readdata_r;
   assign response = response_r;
   assign adv_word = adv_r;
   assign next_page_able = adv_r[pabr_pkg::ADV_NP];
   assign remote_fault_adv = adv_r[pabr_pkg::ADV_RF];
endmodule // pabr_regs

// File: pabr_regs_monitor.sv
// Checker for the register bank ports.
// Assumes one clock domain and the two-cycle bus access of the bank.
`timescale 1ns/1ps
module pabr_regs_monitor (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Bus
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic [1:0] response,
   input wire logic waitrequest,
   // Advertisement
   input wire logic [15:0] adv_word,
   input wire logic next_page_able,
   input wire logic remote_fault_adv
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   one_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("second wait cycle");
   adv_reset_a: assert property ($rose(resetn) |-> adv_word == 16'h0101)
      else $error("bad adv reset");
   rsv_zero_a: assert property (!adv_word[14] && !adv_word[9])
      else $error("reserved bit set");
   np_flag_a: assert property (next_page_able == adv_word[15])
      else $error("next page flag");
   rf_flag_a: assert property (remote_fault_adv == adv_word[13])
      else $error("remote fault flag");
   adv_write_a: assert property (write && !waitrequest && address == 6'h10 &&
      byteenable[1:0] == 2'b11 |=> {16'h0000, adv_word} == ($past(writedata) & 32'h0000bdff))
      else $error("adv write");
   adv_hold_a: assert property (!(write && address == 6'h10) |=> $stable(adv_word))
      else $error("adv changed");
   unmapped_a: assert property (read && waitrequest && address == 6'h20
      |=> readdata == 32'h0 && response == 2'h3)
      else $error("unmapped read");
endmodule // pabr_regs_monitor

bind pabr_regs pabr_regs_monitor pabr_regs_monitor_inst (.clk_sys(clk_sys), .resetn(resetn),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .byteenable(byteenable), .readdata(readdata), .response(response),
   .waitrequest(waitrequest), .adv_word(adv_word), .next_page_able(next_page_able),
   .remote_fault_adv(remote_fault_adv));

// File: pabr_link_partner.sv
// Model of the remote link partner handing base pages to the bank.
// Assumes send is called just after a rising clk_sys edge.
`timescale 1ns/1ps
module pabr_link_partner (
   // Clock
   input wire logic clk_sys,
   // Page out
   output logic page_strobe,
   output logic [15:0] page_word
);
   initial begin
      page_strobe = 1'b0;
      page_word = 16'h0000;
   end
   task automatic send(input logic [15:0] w);
      page_strobe <= 1'b1;
      page_word <= w;
      @(posedge clk_sys);
      page_strobe <= 1'b0;
      // The word is no longer valid, so show its inverse rather than a stale copy.
      page_word <= ~w;
   endtask
endmodule // pabr_link_partner

// File: tb_top.sv
// Self-checking bench for the register bank.
// Assumes the bank answers each access after one wait cycle.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
   $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module tb_top;
   logic clk_sys, resetn, read, write, waitrequest, page_strobe, np, rf;
   logic [5:0] address;
   logic [31:0] writedata, readdata, seed;
   logic [3:0] byteenable;
   logic [1:0] response, rs;
   logic [15:0] page_word, adv_word, rd, m, w;
   int num_errors, num_checks;
   pabr_regs pabr_regs_inst (.clk_sys(clk_sys), .resetn(resetn), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .response(response), .waitrequest(waitrequest),
      .page_strobe(page_strobe), .page_word(page_word), .adv_word(adv_word),
      .next_page_able(np), .remote_fault_adv(rf));
   pabr_link_partner pabr_link_partner_inst (.clk_sys(clk_sys), .page_strobe(page_strobe),
      .page_word(page_word));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   function logic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction
   function automatic logic [15:0] adv_exp(input logic [15:0] o, d, input logic [1:0] be);
      logic [15:0] k;
      k = {{8{be[1]}}, {8{be[0]}}};
      return ((d & k) | (o & ~k)) & 16'hbdff;
   endfunction
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic acc(input logic we, input logic [5:0] a, input logic [15:0] d,
      input logic [1:0] be);
      int n;
      n = 0;
      address <= a;
      read <= ~we;
      write <= we;
      writedata <= {16'h0000, d};
      byteenable <= {2'b00, be};
      do begin
         @(posedge clk_sys);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      if (n >= 20) begin
         num_errors++;
         summarize();
      end
      rd = readdata[15:0];
      rs = response;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk_sys);
   endtask
   initial begin
      repeat (5000) @(posedge clk_sys);
      num_errors++;
      summarize();
   end
   initial begin
      {resetn, read, write, address, writedata, byteenable} = '0;
      seed = 32'h07b5;
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      acc(1'b0, 6'h0c, 16'h0000, 2'b00);
      `CHK(rd[15:4], {pabr_pkg::ID_OUI_RESET, pabr_pkg::ID_MODEL_RESET})
      acc(1'b0, 6'h10, 16'h0000, 2'b00);
      `CHK(rd, 16'h0101)
      acc(1'b0, 6'h14, 16'h0000, 2'b00);
      `CHK({rs, rd}, 18'h00000)
      $display("reset values done");
      m = 16'h0101;
      for (int i = 0; i < 12; i++) begin
         w = (((i == 0) ? 16'hffff : rnd()) & 16'he21f) | 16'h0100;
         acc(1'b1, 6'h10, w, i[1:0] ^ 2'b11);
         m = adv_exp(m, w, i[1:0] ^ 2'b11);
         acc(1'b0, 6'h10, 16'h0000, 2'b00);
         `CHK(rd, m)
         `CHK({np, rf, adv_word}, {m[15], m[13], m})
      end
      acc(1'b1, 6'h10, 16'h0101, 2'b11);
      w = rnd();
      acc(1'b1, 6'h0c, w, 2'b11);
      acc(1'b0, 6'h0c, 16'h0000, 2'b00);
      `CHK(rd, w)
      $display("writes done");
      for (int i = 0; i < 6; i++) begin
         w = (i == 0) ? 16'hffff : rnd();
         pabr_link_partner_inst.send(w);
         acc(1'b1, 6'h14, ~w, 2'b11);
         acc(1'b0, 6'h14, 16'h0000, 2'b00);
         `CHK(rd, w)
      end
      acc(1'b0, 6'h11, 16'h0000, 2'b00);
      `CHK({rs, rd}, 18'h30000)
      acc(1'b1, 6'h18, 16'h0000, 2'b11);
      pabr_link_partner_inst.send(~w);
      acc(1'b0, 6'h14, 16'h0000, 2'b00);
      `CHK(rd, w)
      acc(1'b0, 6'h18, 16'h0000, 2'b00);
      `CHK(rd, 16'h0000)
      acc(1'b0, 6'h1c, 16'h0000, 2'b00);
      `CHK(rd, 16'h0001)
      acc(1'b1, 6'h18, 16'h0001, 2'b11);
      acc(1'b0, 6'h20, 16'h0000, 2'b00);
      `CHK({rs, rd}, 18'h30000)
      $display("pages done");
      resetn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      acc(1'b0, 6'h10, 16'h0000, 2'b00);
      `CHK(rd, 16'h0101)
      acc(1'b0, 6'h14, 16'h0000, 2'b00);
      `CHK(rd, 16'h0000)
      acc(1'b0, 6'h18, 16'h0000, 2'b00);
      `CHK(rd, 16'h0001)
      acc(1'b0, 6'h1c, 16'h0000, 2'b00);
      `CHK(rd, 16'h0000)
      $display("second reset done");
      summarize();
   end
endmodule // tb_top
